// File: asdr_defines.svh
/*
 * Constants of the converter serial host port: clock rate, command codes,
 * timing counts and reset values.
 * Assumes a 20 MHz system clock that also stands for the master clock.
 */
// Behaviour
// - SPI mode 1: change on rise, sample on fall
// - Chip select high resets frame, tri-states pin
// - Data-ready output ignores chip select level
// - Shared pin carries read data during read
// - Shared pin mirrors data-ready while selected
// - Auto-reset: byte must finish within timeout
// - Completed byte rearms timeout on next rise
// - Clock held low for timeout resets frame
// - Auto-reset runs only when enabled, default off
// - Continuous: ready high at start, low per result
// - Unread result: ready pulses high sixteen cycles
// - Late old read delays fall, sets status
// - Pulse mode: ready stays low through reads
// - Status ready set only for unread result
// - Response: status, three result bytes, check
// - Status byte prepended only when append enabled
// - Results 24-bit two's complement, MSB first
// - Command executes after byte two or four
`ifndef ASDR_DEFINES_SVH
`define ASDR_DEFINES_SVH

// Master clock rate, documented timeout figure and ready pulse length
`define ASDR_CLK_HZ 20000000
`define ASDR_TIMEOUT_CYC 65536
`define ASDR_READY_PULSE_CYC 16
// Command opcodes handled by this port
`define ASDR_CMD_READ_DATA 8'h12
`define ASDR_CMD_READ_STATUS 8'h21
// CRC-8 polynomial low bits and preset
`define ASDR_CRC_POLY 8'h07
`define ASDR_CRC_INIT 8'hFF
// Status byte bit that reports new data
`define ASDR_STAT_READY_BIT 2

`endif

// File: asdr_pkg.sv
/*
 * Types of the converter serial host port.
 * Assumes the defines header is compiled alongside.
 */
package asdr_pkg;
    // Frame phases of the serial port
    typedef enum logic [1:0] {
        ASDR_CMD = 2'b00,
        ASDR_RESP = 2'b01,
        ASDR_DONE = 2'b10
    } asdr_phase_e;
endpackage

// File: asdr_spi_port.sv
/*
 * Serial host port of a converter: mode 1 shift logic, chip-select and
 * auto-reset of the frame, data-ready sequencing and the shared pin.
 * Assumes the conversion core gives a start level, a one-cycle result
 * strobe, a 24-bit result and an early-warning strobe 16 cycles ahead.
 */
`timescale 1ns/100ps
`include "asdr_defines.svh"

module asdr_spi_port (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic shared_output_ready_pin_o,
    output logic shared_output_ready_pin_oe_n,
    output logic conv_ready_n,
    // Configuration bits
    input wire logic spi_autoreset_en,
    input wire logic status_append_en,
    input wire logic crc_en,
    input wire logic pulse_mode,
    input wire logic [7:0] status_other,
    // Conversion core
    input wire logic conv_running,
    input wire logic result_soon,
    input wire logic result_valid,
    input wire logic [23:0] result_data,
    // Status
    output logic status_ready,
    output logic cmd_strobe,
    output logic [7:0] cmd_byte
);
    // Two-stage synchronisers for the link pins
    logic [1:0] cs_s_q, sclk_s_q, din_s_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cs_s_q <= 2'h3;
            sclk_s_q <= 2'h0;
            din_s_q <= 2'h0;
        end else begin
            cs_s_q <= {cs_s_q[0], cs_n};
            sclk_s_q <= {sclk_s_q[0], sclk};
            din_s_q <= {din_s_q[0], din};
        end
    end

    // Edge detection works on the second stage only
    logic sclk_d1_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) sclk_d1_q <= 1'b0;
        else sclk_d1_q <= sclk_s_q[1];
    end
    logic cs_act, sclk_rise, sclk_fall;
    assign cs_act = ~cs_s_q[1];
    assign sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
    assign sclk_fall = ~sclk_s_q[1] & sclk_d1_q;

    // Auto-reset timer; counts system clocks, so it needs no link edges
    logic [16:0] to_cnt_q;
    logic to_run_q;
    logic [2:0] bit_cnt_q;
    logic frame_rst;
    logic timeout_hit, idle_hit;
    assign timeout_hit = to_run_q && to_cnt_q >= 17'(`ASDR_TIMEOUT_CYC);
    assign idle_hit = !to_run_q && !sclk_s_q[1] && to_cnt_q >= 17'(`ASDR_TIMEOUT_CYC);
    assign frame_rst = !cs_act || (spi_autoreset_en && (timeout_hit || idle_hit));

    // Timer: armed by the first rise of a byte, cleared when it completes
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !spi_autoreset_en || frame_rst) begin
            to_cnt_q <= 17'h0;
            to_run_q <= 1'b0;
        end else if (sclk_rise && bit_cnt_q == 3'h0 && !to_run_q) begin
            to_cnt_q <= 17'h0;
            to_run_q <= 1'b1;
        end else if (sclk_fall && bit_cnt_q == 3'h7) begin
            to_cnt_q <= 17'h0;
            to_run_q <= 1'b0;
        end else if (!to_run_q && sclk_s_q[1]) begin
            to_cnt_q <= 17'h0; // Clock high breaks an idle-low stretch
        end else if (to_cnt_q != 17'h1FFFF) begin
            to_cnt_q <= to_cnt_q + 17'h1;
        end
    end

    // Receive shifter, sampled on falling edges
    logic [7:0] rx_q;
    logic [1:0] byte_idx_q;
    logic byte_done;
    logic [7:0] rx_full;
    assign rx_full = {rx_q[6:0], din_s_q[1]};
    assign byte_done = sclk_fall && bit_cnt_q == 3'h7;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || frame_rst) begin
            rx_q <= 8'h0;
            bit_cnt_q <= 3'h0;
        end else if (sclk_fall) begin
            rx_q <= rx_full;
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // Command phase and byte counting
    asdr_pkg::asdr_phase_e phase_q;
    logic [7:0] op_q;
    logic [2:0] resp_left_q;
    logic exec;
    assign exec = byte_done && phase_q == asdr_pkg::ASDR_CMD &&
                  byte_idx_q == (crc_en ? 2'h3 : 2'h1);
    logic is_rdata, is_rstat;
    assign is_rdata = op_q == `ASDR_CMD_READ_DATA;
    assign is_rstat = op_q == `ASDR_CMD_READ_STATUS;

    // Response length: read data is optional status, three result bytes, optional check; status read is status, optional check
    logic [2:0] resp_len;
    always_comb begin
        if (is_rdata) resp_len = 3'h3 + {2'h0, status_append_en} + {2'h0, crc_en};
        else if (is_rstat) resp_len = 3'h1 + {2'h0, crc_en};
        else resp_len = 3'h0;
    end

    // Frame state: incomplete frames vanish on frame reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst || frame_rst) begin
            phase_q <= asdr_pkg::ASDR_CMD;
            byte_idx_q <= 2'h0;
            op_q <= 8'h0;
            resp_left_q <= 3'h0;
        end else if (byte_done) begin
            case (phase_q)
                asdr_pkg::ASDR_CMD: begin
                    if (byte_idx_q == 2'h0) op_q <= rx_full;
                    if (exec) begin
                        byte_idx_q <= 2'h0;
                        resp_left_q <= resp_len;
                        phase_q <= (resp_len != 3'h0) ? asdr_pkg::ASDR_RESP : asdr_pkg::ASDR_CMD;
                    end else begin
                        byte_idx_q <= byte_idx_q + 2'h1;
                    end
                end
                asdr_pkg::ASDR_RESP: begin
                    resp_left_q <= resp_left_q - 3'h1;
                    if (resp_left_q == 3'h1) phase_q <= asdr_pkg::ASDR_DONE;
                end
                asdr_pkg::ASDR_DONE: phase_q <= asdr_pkg::ASDR_CMD;
                default: phase_q <= asdr_pkg::ASDR_CMD;
            endcase
        end
    end

    // Result holding and new-data flag; a fresh result beats the clear
    logic [23:0] held_q;
    logic new_q, late_hold_q;
    logic read_start, read_end;
    assign read_start = exec && is_rdata;
    assign read_end = byte_done && phase_q == asdr_pkg::ASDR_RESP &&
                      resp_left_q == 3'h1 && is_rdata;
    logic [23:0] pend_q; // Result that arrived while a read was shifting out
    logic soon_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            held_q <= 24'h0;
            new_q <= 1'b0;
            late_hold_q <= 1'b0;
        end else begin
            if (result_valid && !(phase_q == asdr_pkg::ASDR_RESP && is_rdata)) begin
                held_q <= result_data;
                new_q <= 1'b1;
                late_hold_q <= 1'b0;
            end else if (result_valid) begin
                late_hold_q <= 1'b1; // Old data out; land after the read
            end else if (read_end && late_hold_q) begin
                late_hold_q <= 1'b0;
                held_q <= pend_q; // Late result lands now
                new_q <= 1'b1;
            end else if (read_start) begin
                new_q <= 1'b0;
            end
        end
    end
    // Every arriving result is captured here at once; a mid-read one reaches held_q when the read finishes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) pend_q <= 24'h0;
        else if (result_valid) pend_q <= result_data;
    end
    assign status_ready = new_q;

    // Data-ready output sequencing, independent of chip select
    logic rdy_n_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdy_n_q <= 1'b1;
            soon_q <= 1'b0;
        end else if (!conv_running) begin
            rdy_n_q <= 1'b1;
            soon_q <= 1'b0;
        end else if (result_valid && !late_hold_q &&
                     !(phase_q == asdr_pkg::ASDR_RESP && is_rdata)) begin
            rdy_n_q <= 1'b0;
            soon_q <= 1'b0;
        end else if (read_end && late_hold_q) begin
            rdy_n_q <= 1'b0;
        end else if (read_end && !pulse_mode) begin
            rdy_n_q <= 1'b1;
        end else if (result_soon && !pulse_mode) begin
            rdy_n_q <= 1'b1;
            soon_q <= 1'b1;
        end
    end
    assign conv_ready_n = rdy_n_q;

    // Response byte source and check byte
    logic [7:0] stat_byte, tx_byte, crc_q;
    // New-data bit is frozen at execution, before the read itself clears it
    logic stat_new_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) stat_new_q <= 1'b0;
        else if (exec) stat_new_q <= new_q | result_valid;
    end
    // The flag replaces its bit of the other status bits rather than merging
    assign stat_byte = (status_other & ~(8'h01 << `ASDR_STAT_READY_BIT)) |
                       (8'(stat_new_q) << `ASDR_STAT_READY_BIT);
    always_comb begin
        tx_byte = crc_q;
        if (is_rstat && resp_left_q == resp_len) tx_byte = stat_byte;
        else if (is_rdata) begin
            case (resp_len - resp_left_q - {2'h0, status_append_en})
                3'h0: tx_byte = held_q[23:16];
                3'h1: tx_byte = held_q[15:8];
                3'h2: tx_byte = held_q[7:0];
                default: tx_byte = crc_q;
            endcase
            if (status_append_en && resp_left_q == resp_len) tx_byte = stat_byte;
        end
    end

    // Transmit shifter, loaded per byte and changed on rising edges
    logic [7:0] tx_q;
    logic [7:0] crc_next;
    always_comb begin
        crc_next = crc_q;
        for (int i = 7; i >= 0; i--) begin
            crc_next = (crc_next[7] ^ tx_byte[i]) ?
                       ((crc_next << 1) ^ `ASDR_CRC_POLY) : (crc_next << 1);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || frame_rst || exec) begin
            tx_q <= 8'h0;
            crc_q <= `ASDR_CRC_INIT;
        end else if (phase_q == asdr_pkg::ASDR_RESP && sclk_rise && bit_cnt_q == 3'h0) begin
            tx_q <= tx_byte;
            if (resp_left_q != 3'h1 || !crc_en) crc_q <= crc_next;
        end else if (sclk_rise) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Shared pin: read data during a read, else mirrors data-ready
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shared_output_ready_pin_o <= 1'b1;
            shared_output_ready_pin_oe_n <= 1'b1;
        end else begin
            shared_output_ready_pin_oe_n <= !cs_act;
            if (phase_q == asdr_pkg::ASDR_RESP)
                shared_output_ready_pin_o <= (sclk_rise && bit_cnt_q == 3'h0) ?
                                             tx_byte[7] : tx_q[7];
            else
                shared_output_ready_pin_o <= rdy_n_q;
        end
    end

    // Command byte report to the core
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd_strobe <= 1'b0;
            cmd_byte <= 8'h0;
        end else begin
            cmd_strobe <= exec;
            if (exec) cmd_byte <= op_q;
        end
    end

    // Assertions
    a_cs_tristate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !cs_act |=> shared_output_ready_pin_oe_n)
        else $error("shared pin driven while deselected");
    a_frame_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !cs_act |=> bit_cnt_q == 3'h0 && phase_q == asdr_pkg::ASDR_CMD)
        else $error("frame not reset by deselect");
    a_ready_mirror: assert property (@(posedge sys_clk) disable iff (sys_rst)
        phase_q != asdr_pkg::ASDR_RESP |=> shared_output_ready_pin_o == $past(rdy_n_q))
        else $error("shared pin not mirroring ready");
    a_autorst_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !spi_autoreset_en |=> to_cnt_q == 17'h0)
        else $error("timer runs while disabled");
    a_timeout_fire: assert property (@(posedge sys_clk) disable iff (sys_rst)
        spi_autoreset_en && cs_act && timeout_hit |=> bit_cnt_q == 3'h0)
        else $error("timeout did not reset frame");
    a_rearm_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
        spi_autoreset_en && cs_act && byte_done |=> !to_run_q)
        else $error("timer not rearmed after byte");
    a_pulse_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pulse_mode && conv_running && !rdy_n_q && !result_soon |=> !rdy_n_q)
        else $error("pulse mode ready rose without start");
    a_ready_new: assert property (@(posedge sys_clk) disable iff (sys_rst)
        result_valid && !(phase_q == asdr_pkg::ASDR_RESP) |=> status_ready)
        else $error("status ready not set on new result");
    a_cmd_exec: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exec |=> cmd_strobe ##1 !cmd_strobe)
        else $error("command strobe not one cycle");
    c_read_data: cover property (@(posedge sys_clk) read_start ##[1:1000] read_end);
    c_auto_reset: cover property (@(posedge sys_clk) spi_autoreset_en && timeout_hit);
    c_late_read: cover property (@(posedge sys_clk) late_hold_q && read_end);
    c_ready_pulse: cover property (@(posedge sys_clk) soon_q && result_valid);
endmodule

// File: asdr_host_model.sv
/*
 * Host controller model for the converter serial port: mode 1 master.
 * Assumes the shared pin is only trusted while its enable is low.
 */
`timescale 1ns/100ps
module asdr_host_model (
    // Clock
    input wire logic sys_clk,
    // Link outputs
    output logic cs_n,
    output logic sclk,
    output logic din,
    // Shared pin from the port
    input wire logic pin_o,
    input wire logic pin_oe_n
);
    // Idle link: deselected, clock low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // One bit: drive on the rise, sample on the fall, 8 cycles a bit
    task automatic bit_x(input logic tx, output logic rx);
        @(posedge sys_clk) #1;
        sclk = 1'b1;
        din = tx;
        repeat (4) @(posedge sys_clk);
        #1;
        // A released line shows the wrong level, never a lucky match
        rx = pin_oe_n ? ~pin_o : pin_o;
        sclk = 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // Whole frame: command bits out, then response bits in, MSB first
    task automatic frame(input logic [31:0] cmd, input int ncmd, input int nrx,
                         input logic keep, output logic [39:0] rx);
        logic r;
        rx = '0;
        @(posedge sys_clk) #1;
        cs_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < ncmd + nrx; i++) begin
            // Unused data line toggles so a stale level cannot help
            bit_x(i < ncmd ? cmd[31 - i] : ~din, r);
            if (i >= ncmd) begin
                rx = {rx[38:0], r};
            end
        end
        repeat (4) @(posedge sys_clk);
        #1;
        din = ~din;
        // Clock stays low after the frame
        if (!keep) begin
            cs_n = 1'b1;
        end
    endtask
endmodule

// File: asdr_spi_port_tb.sv
/*
 * Self-checking bench of the converter serial port with core stimulus.
 * Assumes the port and the host model are compiled before it.
 */
`timescale 1ns/100ps
module asdr_spi_port_tb;
    // Clock, reset and pins
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cs_n, sclk, din, pin_o, pin_oe_n, conv_ready_n, status_ready, cmd_strobe;
    // Configuration and core stimulus
    logic autoreset_en = 1'b0, append_en = 1'b0, crc_en = 1'b0, pulse_mode = 1'b0;
    logic conv_running = 1'b0, result_soon = 1'b0, result_valid = 1'b0;
    logic [7:0] status_other = 8'h00, cmd_byte;
    logic [23:0] result_data = 24'h0, seed = 24'h39, d, dn;
    logic [39:0] rx;
    // Host calibration words, preset to zero offset and unity gain
    logic [23:0] ofs_w = 24'h000000, gain_w = 24'h400000;
    logic signed [25:0] sum_rd = '0, sum_ex = '0;
    int n_fail = 0, comparisons = 0, n_strobe = 0, nb;

    always #25 sys_clk = ~sys_clk;
    // Count executed commands
    always @(posedge sys_clk) if (cmd_strobe === 1'b1) n_strobe <= n_strobe + 1;

    asdr_spi_port asdr_spi_port_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n),
        .sclk(sclk), .din(din), .shared_output_ready_pin_o(pin_o),
        .shared_output_ready_pin_oe_n(pin_oe_n), .conv_ready_n(conv_ready_n),
        .spi_autoreset_en(autoreset_en), .status_append_en(append_en), .crc_en(crc_en),
        .pulse_mode(pulse_mode), .status_other(status_other), .conv_running(conv_running),
        .result_soon(result_soon), .result_valid(result_valid), .result_data(result_data),
        .status_ready(status_ready), .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte));
    asdr_host_model asdr_host_model_inst (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
        .din(din), .pin_o(pin_o), .pin_oe_n(pin_oe_n));

    // Random source, repeatable from its fixed start
    function automatic logic [23:0] lfsr_next(logic [23:0] s);
        return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
    endfunction
    // Check byte over the low n bits, preset all ones
    function automatic logic [7:0] crc8(logic [39:0] v, int n);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = n - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    // Status byte with the new-data bit in place
    function automatic logic [7:0] st(logic nw);
        return {status_other[7:3], nw, status_other[1:0]};
    endfunction
    // Expected read-data response for the current options
    function automatic logic [39:0] exp_rd(logic [23:0] v);
        logic [39:0] e;
        e = append_en ? {8'h00, st(1'b1), v} : {16'h0000, v};
        if (crc_en) begin
            e = {e[31:0], crc8(e, append_en ? 32 : 24)};
        end
        return e;
    endfunction

    // Host gain word: expected code over averaged code, times unity
    function automatic logic [23:0] gain_word(logic [23:0] avg);
        if (avg == 24'h0) return 24'h400000;
        return 24'((48'h799998 * 48'h400000) / {24'h0, avg});
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Early warning, then the result 16 cycles later; pc checks the high pulse
    task automatic produce(output logic [23:0] v, input logic pc);
        seed = lfsr_next(seed);
        v = seed;
        tick(1);
        result_soon = 1'b1;
        tick(1);
        result_soon = 1'b0;
        tick(8);
        if (pc) chk(conv_ready_n, 1'b1);
        tick(7);
        result_valid = 1'b1;
        result_data = v;
        tick(1);
        result_valid = 1'b0;
        tick(4);
        if (pc) chk(conv_ready_n, 1'b0);
    endtask
    // Read command, four bytes in check mode
    task automatic rd(input logic [7:0] op, input logic keep, output logic [39:0] r);
        nb = (op == 8'h21) ? 8 : 24 + (append_en ? 8 : 0) + (crc_en ? 8 : 0);
        asdr_host_model_inst.frame({op, 8'h00, crc8({24'h0, op, 8'h00}, 16), 8'h00},
            crc_en ? 32 : 16, nb, keep, r);
    endtask
    task automatic close_out();
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard: the run needs about 70000 cycles
    initial begin
        repeat (90000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end

    initial begin
        tick(3);
        sys_rst = 1'b0;
        tick(4);
        chk({conv_ready_n, pin_oe_n, status_ready}, 3'b110);
        conv_running = 1'b1;
        // Every option pair of the read-data response
        for (int k = 0; k < 4; k++) begin
            append_en = k[0];
            crc_en = k[1];
            status_other = seed[7:0];
            produce(d, 1'b0);
            chk({conv_ready_n, status_ready}, 2'b01);
            asdr_host_model_inst.frame(32'h0, 0, 0, 1'b1, rx);
            chk({pin_oe_n, pin_o}, {1'b0, conv_ready_n});
            rd(8'h12, 1'b1, rx); // Read well ahead of the next result
            chk(rx, exp_rd(d));
            sum_rd = sum_rd + signed'(crc_en ? rx[31:8] : rx[23:0]);
            sum_ex = sum_ex + signed'(d);
            chk(cmd_byte, 8'h12);
            chk({conv_ready_n, status_ready}, 2'b10);
            chk(pin_o, conv_ready_n);
            asdr_host_model_inst.frame(32'h0, 0, 0, 1'b0, rx);
            tick(4);
            chk(pin_oe_n, 1'b1);
        end
        // Host calibration words from the four reads against the stimulus
        ofs_w = 24'(sum_rd >>> 2);
        chk(ofs_w, 24'(sum_ex >>> 2));
        gain_w = 24'h3CCCCC; // Scaled down while averaging
        gain_w = gain_word(ofs_w);
        chk(gain_w, gain_word(24'(sum_ex >>> 2)));
        append_en = 1'b0;
        crc_en = 1'b0;
        // Unread result, then the next one: the newest is returned
        produce(dn, 1'b0);
        produce(d, 1'b1);
        rd(8'h12, 1'b0, rx);
        chk(rx[23:0], d);
        // A result landing mid-read: old data, fall deferred
        produce(d, 1'b0);
        fork
            rd(8'h12, 1'b0, rx);
            begin
                tick(150);
                produce(dn, 1'b0);
            end
        join
        chk(rx[23:0], d);
        chk({conv_ready_n, status_ready}, 2'b01);
        rd(8'h21, 1'b0, rx); // Status poll within one data period
        chk(rx[7:0], st(1'b1));
        chk(cmd_byte, 8'h21);
        // Pulse mode keeps ready low through the read
        pulse_mode = 1'b1;
        produce(d, 1'b0);
        rd(8'h12, 1'b0, rx);
        chk({conv_ready_n, rx[23:0]}, {1'b0, d});
        // Frame cut short by chip select is discarded
        nb = n_strobe;
        asdr_host_model_inst.frame({8'h12, 24'h0}, 8, 0, 1'b0, rx);
        tick(8);
        chk(n_strobe, nb);
        // Stray clock edges leave a byte unfinished; the byte timeout recovers the frame
        autoreset_en = 1'b1;
        asdr_host_model_inst.frame(32'hA0000000, 3, 0, 1'b1, rx);
        tick(65540);
        rd(8'h21, 1'b0, rx);
        chk(rx[7:0], st(1'b0));
        close_out();
    end
endmodule
